// ### hdl/breaker_keypad_control.sv
// Decided for this implementation: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ns
// Summary of operation
// - Three-pole mode: one input gives position
// - Per-pole mode: report only when poles agree
// - Two breakers; single one is breaker one
// - Refuse commands once permit window expires
// - Prompt password when enabled and window closed
// - Select prompt lasts 30 s or select
// - Second select picks breaker one, 30 s
// - Close key arms 20 s; again closes
// - Open key arms 20 s; again opens
// - Further select toggles to other breaker
// - Any other key aborts the sequence
// - One-breaker sequence same as two-breaker
// - Setting bounded by minimum, maximum, step
// - Up steps, wraps maximum to minimum
// - Down steps, wraps minimum to maximum
// - Digits enter MSD first; escape restores
// - Enter commits altered value
// - Display is two lines, twenty columns
// - Idle keypad shows default message
// - Event message overrides default message
// - Menu key cycles top-level pages
// - Commands blocked until device programmed
module breaker_keypad_control
#(
  parameter int unsigned TICK_CYCLES = keypad_pkg::TICK_CYCLES,
  parameter int unsigned VAL_W       = 16,
  parameter int unsigned NUM_PAGES   = 4
)
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Keypad: one-cycle strobe with code
  input  wire logic        key_valid,
  input  wire logic [4:0]  key_code,
  input  wire logic [3:0]  key_digit,
  input  wire logic        event_msg,
  // Breaker auxiliary inputs
  input  wire logic [2:0]  first_poles,
  input  wire logic [2:0]  second_poles,
  // Outputs
  output logic             close_action_first_breaker,
  output logic             close_action_second_breaker,
  output logic             open_action_first_breaker,
  output logic             open_action_second_breaker,
  output logic [3:0]       msg_code,
  output logic [1:0]       menu_page,
  output logic             sel_second_breaker,
  output logic [1:0]       first_position,
  output logic [1:0]       second_position,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  typedef logic [VAL_W-1:0] val_t;

  localparam val_t SET_MIN_W = VAL_W'(keypad_pkg::SET_MIN_RST);

  logic [31:0]             ctrl_r;
  val_t                    set_min_r;
  val_t                    set_max_r;
  val_t                    set_step_r;
  val_t                    set_val_r;
  val_t                    edit_val_r;
  logic                    editing_r;
  logic [31:0]             tick_cnt_r;
  logic                    tick_r;
  logic [11:0]             permit_cnt_r;
  logic [5:0]              seq_cnt_r;
  keypad_pkg::ctl_state_t  state_r;
  keypad_pkg::ctl_state_t  state_nxt;
  logic                    sel2_r;
  logic                    cmd_close_r;
  logic                    cmd_open_r;
  logic [1:0]              page_r;
  logic                    aw_held_r;
  logic                    w_held_r;
  logic [7:0]              awaddr_r;
  logic [31:0]             wdata_r;
  logic [3:0]              wstrb_r;
  logic                    p1_closed;
  logic                    p1_open;
  logic                    p2_closed;
  logic                    p2_open;
  logic                    bkr_key;
  logic                    other_key;
  logic                    permitted;
  logic                    timed_out;
  logic                    pulse_close;
  logic                    pulse_open;

  // Position trackers for both breakers
  breaker_position u_pos_one
  (
    .aclk             (aclk),
    .aresetn          (aresetn),
    .single_pole_mode (ctrl_r[keypad_pkg::CTRL_PERPOLE_A]),
    .pole_closed      (first_poles),
    .pos_closed_r     (p1_closed),
    .pos_open_r       (p1_open),
    .pos_valid_r      ()
  );

  breaker_position u_pos_two
  (
    .aclk             (aclk),
    .aresetn          (aresetn),
    .single_pole_mode (ctrl_r[keypad_pkg::CTRL_PERPOLE_B]),
    .pole_closed      (second_poles),
    .pos_closed_r     (p2_closed),
    .pos_open_r       (p2_open),
    .pos_valid_r      ()
  );

  // Second breaker reads idle when unused
  assign first_position  = {p1_closed, p1_open};
  assign second_position = ctrl_r[keypad_pkg::CTRL_TWO_BKR] ? {p2_closed, p2_open}
                           : 2'b00;

  // One-second tick from the system clock
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tick_cnt_r <= 32'h0000_0000;
      tick_r     <= 1'b0;
    end
    else if (tick_cnt_r == TICK_CYCLES - 1)
    begin
      tick_cnt_r <= 32'h0000_0000;
      tick_r     <= 1'b1;
    end
    else
    begin
      tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
      tick_r     <= 1'b0;
    end
  end

  // Key classification
  assign bkr_key   = key_valid && (key_code == keypad_pkg::KEY_SELECT
                     || key_code == keypad_pkg::KEY_CLOSE || key_code == keypad_pkg::KEY_OPEN);
  assign other_key = key_valid && !bkr_key;
  assign permitted = (permit_cnt_r != 12'h000) || !ctrl_r[keypad_pkg::CTRL_PW_EN];
  assign timed_out = tick_r && (seq_cnt_r == 6'h01);
  assign pulse_close = (state_r == keypad_pkg::ST_ARM_CL) && key_valid
                       && key_code == keypad_pkg::KEY_CLOSE;
  assign pulse_open  = (state_r == keypad_pkg::ST_ARM_OP) && key_valid
                       && key_code == keypad_pkg::KEY_OPEN;

  // Permission window: loaded by password or a command, expires to refused
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      permit_cnt_r <= 12'h000;
    else if ((state_r == keypad_pkg::ST_PASS && ctrl_r[keypad_pkg::CTRL_PASS_OK])
             || pulse_close || pulse_open)
      permit_cnt_r <= 12'(keypad_pkg::PERMIT_WINDOW_S);
    else if (tick_r && permit_cnt_r != 12'h000)
      permit_cnt_r <= permit_cnt_r - 12'h001;
  end

  // Sequence next state; other keys abort from anywhere
  always_comb
  begin
    state_nxt = state_r;
    if (other_key && state_r != keypad_pkg::ST_IDLE)
      state_nxt = keypad_pkg::ST_IDLE;
    else
    begin
      case (state_r)
        keypad_pkg::ST_IDLE:
          if (bkr_key && ctrl_r[keypad_pkg::CTRL_PB_EN])
            state_nxt = permitted ? keypad_pkg::ST_PROMPT : keypad_pkg::ST_PASS;
        keypad_pkg::ST_PASS:
          if (ctrl_r[keypad_pkg::CTRL_PASS_OK])
            state_nxt = keypad_pkg::ST_PROMPT;
          else if (ctrl_r[keypad_pkg::CTRL_PASS_BAD])
            state_nxt = keypad_pkg::ST_IDLE;
        keypad_pkg::ST_PROMPT:
          if (key_valid && key_code == keypad_pkg::KEY_SELECT)
            state_nxt = keypad_pkg::ST_SEL;
          else if (timed_out)
            state_nxt = keypad_pkg::ST_IDLE;
        keypad_pkg::ST_SEL:
          if (key_valid && key_code == keypad_pkg::KEY_CLOSE)
            state_nxt = keypad_pkg::ST_ARM_CL;
          else if (key_valid && key_code == keypad_pkg::KEY_OPEN)
            state_nxt = keypad_pkg::ST_ARM_OP;
          else if (timed_out)
            state_nxt = keypad_pkg::ST_IDLE;
        keypad_pkg::ST_ARM_CL:
          if (pulse_close || timed_out)
            state_nxt = keypad_pkg::ST_IDLE;
          else if (key_valid && key_code == keypad_pkg::KEY_SELECT)
            state_nxt = keypad_pkg::ST_SEL;
        keypad_pkg::ST_ARM_OP:
          if (pulse_open || timed_out)
            state_nxt = keypad_pkg::ST_IDLE;
          else if (key_valid && key_code == keypad_pkg::KEY_SELECT)
            state_nxt = keypad_pkg::ST_SEL;
        default:
          state_nxt = keypad_pkg::ST_IDLE;
      endcase
    end
  end

  // State register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      state_r <= keypad_pkg::ST_IDLE;
    else
      state_r <= state_nxt;
  end

  // Timeout counter reloads on every state entry, including reselect
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      seq_cnt_r <= 6'h00;
    else if (state_nxt != state_r || (state_r == keypad_pkg::ST_SEL && key_valid
             && key_code == keypad_pkg::KEY_SELECT))
    begin
      case (state_nxt)
        keypad_pkg::ST_PROMPT: seq_cnt_r <= 6'(keypad_pkg::SELECT_PROMPT_S);
        keypad_pkg::ST_SEL:    seq_cnt_r <= 6'(keypad_pkg::ACTION_WINDOW_S);
        keypad_pkg::ST_ARM_CL: seq_cnt_r <= 6'(keypad_pkg::ARM_WINDOW_S);
        keypad_pkg::ST_ARM_OP: seq_cnt_r <= 6'(keypad_pkg::ARM_WINDOW_S);
        default:               seq_cnt_r <= 6'h00;
      endcase
    end
    else if (tick_r && seq_cnt_r != 6'h00)
      seq_cnt_r <= seq_cnt_r - 6'h01;
  end

  // Breaker selection; one-breaker setup never leaves breaker one
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      sel2_r <= 1'b0;
    else if (state_r == keypad_pkg::ST_PROMPT && state_nxt == keypad_pkg::ST_SEL)
      sel2_r <= 1'b0;
    else if (state_r != keypad_pkg::ST_PROMPT && state_r != keypad_pkg::ST_IDLE
             && state_nxt == keypad_pkg::ST_SEL && key_valid
             && key_code == keypad_pkg::KEY_SELECT)
      sel2_r <= ctrl_r[keypad_pkg::CTRL_TWO_BKR] ? ~sel2_r : 1'b0;
  end

  // Command pulses, gated by the programmed state
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cmd_close_r <= 1'b0;
      cmd_open_r  <= 1'b0;
    end
    else
    begin
      cmd_close_r <= pulse_close && ctrl_r[keypad_pkg::CTRL_PROGRAMMED];
      cmd_open_r  <= pulse_open && ctrl_r[keypad_pkg::CTRL_PROGRAMMED];
    end
  end

  assign close_action_first_breaker  = cmd_close_r && !sel2_r;
  assign close_action_second_breaker = cmd_close_r && sel2_r;
  assign open_action_first_breaker   = cmd_open_r && !sel2_r;
  assign open_action_second_breaker  = cmd_open_r && sel2_r;
  assign sel_second_breaker          = sel2_r;

  // Numeric setting editor; wraps at the bounds
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      edit_val_r <= SET_MIN_W;
      editing_r  <= 1'b0;
      set_val_r  <= SET_MIN_W;
    end
    else if (key_valid && state_r == keypad_pkg::ST_IDLE)
    begin
      if (key_code == keypad_pkg::KEY_UP)
      begin
        editing_r  <= 1'b1;
        edit_val_r <= (edit_val_r > set_max_r - set_step_r || edit_val_r >= set_max_r)
                      ? set_min_r : edit_val_r + set_step_r;
      end
      else if (key_code == keypad_pkg::KEY_DOWN)
      begin
        editing_r  <= 1'b1;
        edit_val_r <= (edit_val_r <= set_min_r + set_step_r - 1'b1)
                      ? set_max_r : edit_val_r - set_step_r;
      end
      else if (key_code[4])
      begin
        editing_r  <= 1'b1;
        edit_val_r <= VAL_W'((editing_r ? edit_val_r : '0) * 10 + key_digit);
      end
      else if (key_code == keypad_pkg::KEY_ESCAPE || key_code == keypad_pkg::KEY_MSGBK)
      begin
        editing_r  <= 1'b0;
        edit_val_r <= set_val_r;
      end
      else if (key_code == keypad_pkg::KEY_ENTER && editing_r)
      begin
        editing_r <= 1'b0;
        if (edit_val_r >= set_min_r && edit_val_r <= set_max_r)
          set_val_r <= edit_val_r;
        else
          edit_val_r <= set_val_r;
      end
    end
  end

  // Menu key cycles heading pages
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      page_r <= 2'h0;
    else if (key_valid && key_code == keypad_pkg::KEY_MENU && state_r == keypad_pkg::ST_IDLE)
      page_r <= (page_r == 2'(NUM_PAGES - 1)) ? 2'h0 : page_r + 2'h1;
  end
  assign menu_page = page_r;

  // Message priority: sequence, then event, then edit, then default
  always_comb
  begin
    case (state_r)
      keypad_pkg::ST_PASS:   msg_code = keypad_pkg::MSG_PASSWORD;
      keypad_pkg::ST_PROMPT: msg_code = keypad_pkg::MSG_PROMPT;
      keypad_pkg::ST_SEL:    msg_code = keypad_pkg::MSG_SELECTED;
      keypad_pkg::ST_ARM_CL: msg_code = keypad_pkg::MSG_ARM_CL;
      keypad_pkg::ST_ARM_OP: msg_code = keypad_pkg::MSG_ARM_OP;
      default:
        if (event_msg)
          msg_code = keypad_pkg::MSG_EVENT;
        else if (editing_r)
          msg_code = keypad_pkg::MSG_EDIT;
        else
          msg_code = keypad_pkg::MSG_DEFAULT;
    endcase
  end

  // AXI4-Lite write channel capture, either order
  assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_r && !s_axi_bvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      awaddr_r  <= 8'h00;
      wdata_r   <= 32'h0000_0000;
      wstrb_r   <= 4'h0;
    end
    else if (aw_held_r && w_held_r)
    begin
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end
    end
  end

  // Register writes; password strobes self-clear after one cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_r       <= keypad_pkg::CTRL_RST;
      set_min_r    <= VAL_W'(keypad_pkg::SET_MIN_RST);
      set_max_r    <= VAL_W'(keypad_pkg::SET_MAX_RST);
      set_step_r   <= VAL_W'(keypad_pkg::SET_STEP_RST);
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= keypad_pkg::RESP_OKAY;
    end
    else
    begin
      ctrl_r[keypad_pkg::CTRL_PASS_OK]  <= 1'b0;
      ctrl_r[keypad_pkg::CTRL_PASS_BAD] <= 1'b0;
      if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (aw_held_r && w_held_r)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= keypad_pkg::RESP_OKAY;
        if (awaddr_r == keypad_pkg::REG_CTRL)
        begin
          if (wstrb_r[0])
            ctrl_r[7:0] <= wdata_r[7:0];
        end
        else if (awaddr_r == keypad_pkg::REG_SET_MIN)
          set_min_r <= wdata_r[VAL_W-1:0];
        else if (awaddr_r == keypad_pkg::REG_SET_MAX)
          set_max_r <= wdata_r[VAL_W-1:0];
        else if (awaddr_r == keypad_pkg::REG_SET_STEP)
          set_step_r <= (wdata_r[VAL_W-1:0] == '0) ? VAL_W'(1) : wdata_r[VAL_W-1:0];
        else if (awaddr_r != keypad_pkg::REG_STATUS && awaddr_r != keypad_pkg::REG_SET_VAL)
          s_axi_bresp <= keypad_pkg::RESP_SLVERR;
      end
    end
  end

  // Read channel: one read at a time
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= keypad_pkg::RESP_OKAY;
    end
    else if (s_axi_rvalid)
    begin
      if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
    else if (s_axi_arvalid)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= keypad_pkg::RESP_OKAY;
      s_axi_rdata  <= 32'h0000_0000;
      if (s_axi_araddr == keypad_pkg::REG_CTRL)
        s_axi_rdata <= {24'h000000, ctrl_r[7:0]};
      else if (s_axi_araddr == keypad_pkg::REG_STATUS)
        s_axi_rdata <= {16'h0000, permit_cnt_r[11:0], 1'b0, state_r};
      else if (s_axi_araddr == keypad_pkg::REG_SET_MIN)
        s_axi_rdata <= 32'(set_min_r);
      else if (s_axi_araddr == keypad_pkg::REG_SET_MAX)
        s_axi_rdata <= 32'(set_max_r);
      else if (s_axi_araddr == keypad_pkg::REG_SET_STEP)
        s_axi_rdata <= 32'(set_step_r);
      else if (s_axi_araddr == keypad_pkg::REG_SET_VAL)
        s_axi_rdata <= 32'(set_val_r);
      else
        s_axi_rresp <= keypad_pkg::RESP_SLVERR;
    end
  end

endmodule

// ### hdl/keypad_pkg.sv
package keypad_pkg;

  // Clock and time base
  localparam int unsigned CLK_HZ            = 125000000;
  localparam int unsigned TICK_CYCLES       = CLK_HZ;
  localparam int unsigned PERMIT_WINDOW_MIN = 30;
  localparam int unsigned PERMIT_WINDOW_S   = PERMIT_WINDOW_MIN * 60;
  localparam int unsigned SELECT_PROMPT_S   = 30;
  localparam int unsigned ACTION_WINDOW_S   = 30;
  localparam int unsigned ARM_WINDOW_S      = 20;

  // Display geometry
  localparam int unsigned DISP_LINES        = 2;
  localparam int unsigned DISP_COLS         = 20;

  // Key codes
  typedef enum logic [4:0] {
    KEY_NONE   = 5'h00,
    KEY_SELECT = 5'h01,
    KEY_CLOSE  = 5'h02,
    KEY_OPEN   = 5'h03,
    KEY_MENU   = 5'h04,
    KEY_UP     = 5'h05,
    KEY_DOWN   = 5'h06,
    KEY_ENTER  = 5'h07,
    KEY_ESCAPE = 5'h08,
    KEY_MSGBK  = 5'h09,
    KEY_DIGIT  = 5'h10
  } key_t;

  // Controller states, Gray along the usual path
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_PASS   = 3'b001,
    ST_PROMPT = 3'b011,
    ST_SEL    = 3'b010,
    ST_ARM_CL = 3'b110,
    ST_ARM_OP = 3'b111
  } ctl_state_t;

  // Display message codes
  typedef enum logic [3:0] {
    MSG_DEFAULT  = 4'h0,
    MSG_PASSWORD = 4'h1,
    MSG_PROMPT   = 4'h2,
    MSG_SELECTED = 4'h3,
    MSG_ARM_CL   = 4'h4,
    MSG_ARM_OP   = 4'h5,
    MSG_EVENT    = 4'h6,
    MSG_EDIT     = 4'h7
  } msg_t;

  // AXI4-Lite register offsets
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_STATUS   = 8'h04;
  localparam logic [7:0] REG_SET_MIN  = 8'h08;
  localparam logic [7:0] REG_SET_MAX  = 8'h0c;
  localparam logic [7:0] REG_SET_STEP = 8'h10;
  localparam logic [7:0] REG_SET_VAL  = 8'h14;

  // Control field positions
  localparam int unsigned CTRL_PROGRAMMED = 0;
  localparam int unsigned CTRL_TWO_BKR    = 1;
  localparam int unsigned CTRL_PW_EN      = 2;
  localparam int unsigned CTRL_PASS_OK    = 3;
  localparam int unsigned CTRL_PASS_BAD   = 4;
  localparam int unsigned CTRL_PERPOLE_A  = 5;
  localparam int unsigned CTRL_PERPOLE_B  = 6;
  localparam int unsigned CTRL_PB_EN      = 7;

  // Reset values
  localparam logic [31:0] CTRL_RST     = 32'h0000_0084;
  localparam logic [15:0] SET_MIN_RST  = 16'h0000;
  localparam logic [15:0] SET_MAX_RST  = 16'h270f;
  localparam logic [15:0] SET_STEP_RST = 16'h0001;
  localparam logic [1:0]  RESP_OKAY    = 2'b00;
  localparam logic [1:0]  RESP_SLVERR  = 2'b10;

endpackage

// ### hdl/breaker_position.sv
`timescale 1ns/1ns
// Breaker position tracker, one per breaker
module breaker_position
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       single_pole_mode,
  input  wire logic [2:0] pole_closed,
  output logic            pos_closed_r,
  output logic            pos_open_r,
  output logic            pos_valid_r
);

  logic agree_closed;
  logic agree_open;

  // Three-pole mode uses pole A alone; per-pole mode needs agreement
  assign agree_closed = single_pole_mode ? (&pole_closed) : pole_closed[0];
  assign agree_open   = single_pole_mode ? ~(|pole_closed) : ~pole_closed[0];

  // Disagreement clears both flags so no position is reported
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pos_closed_r <= 1'b0;
      pos_open_r   <= 1'b0;
      pos_valid_r  <= 1'b0;
    end
    else
    begin
      pos_closed_r <= agree_closed;
      pos_open_r   <= agree_open;
      pos_valid_r  <= agree_closed | agree_open;
    end
  end

endmodule

// ### tb/keypad_partner.sv
`timescale 1ns/1ns
// Operator keypad and breaker auxiliary contacts
module keypad_partner
(
  input  wire logic  aclk,
  output logic       key_valid = 1'b0,
  output logic [4:0] key_code = 5'h00,
  output logic [3:0] key_digit = 4'h0,
  output logic [2:0] first_poles = 3'h0,
  output logic [2:0] second_poles = 3'h0
);
  // One strobe per press; the idle code is scrambled so nothing leans on it
  task press(input logic [4:0] c, input logic [3:0] d);
    key_valid <= 1'b1;
    key_code <= c;
    key_digit <= d;
    @(posedge aclk);
    key_valid <= 1'b0;
    key_code <= ~c;
    key_digit <= ~d;
    @(posedge aclk);
  endtask
endmodule

// ### tb/keypad_props.sv
`timescale 1ns/1ns
// Port checks for the breaker keypad controller
module keypad_props
(
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       key_valid,
  input wire logic [4:0] key_code,
  input wire logic       event_msg,
  input wire logic       close_action_first_breaker,
  input wire logic       close_action_second_breaker,
  input wire logic       open_action_first_breaker,
  input wire logic       open_action_second_breaker,
  input wire logic [3:0] msg_code,
  input wire logic [1:0] menu_page,
  input wire logic       sel_second_breaker
);
  logic cl;
  logic opn;
  // Either breaker commanded
  assign cl = close_action_first_breaker | close_action_second_breaker;
  assign opn = open_action_first_breaker | open_action_second_breaker;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // A key press seen in a given display state
  sequence s_key(k, m);
    key_valid && key_code == k && msg_code == m;
  endsequence
  property p_close_cause;
    $rose(cl) |-> $past(key_valid && key_code == 5'h02 && msg_code == 4'h4);
  endproperty
  a_close_cause: assert property (p_close_cause) else $error("close not armed");
  property p_open_cause;
    $rose(opn) |-> $past(key_valid && key_code == 5'h03 && msg_code == 4'h5);
  endproperty
  a_open_cause: assert property (p_open_cause) else $error("open not armed");
  property p_arm;
    s_key(5'h02, 4'h3) |=> msg_code == 4'h4;
  endproperty
  a_arm: assert property (p_arm) else $error("close key did not arm");
  property p_one_shot;
    cl || opn |=> !(cl || opn);
  endproperty
  a_one_shot: assert property (p_one_shot) else $error("command not one cycle");
  property p_sel;
    cl || opn |-> sel_second_breaker
                  == (close_action_second_breaker || open_action_second_breaker);
  endproperty
  a_sel: assert property (p_sel) else $error("command to wrong breaker");
  property p_abort;
    s_key(5'h08, 4'h3) |=> msg_code inside {4'h0, 4'h6} && !cl && !opn;
  endproperty
  a_abort: assert property (p_abort) else $error("escape did not abort");
  property p_event;
    event_msg |-> msg_code != 4'h0;
  endproperty
  a_event: assert property (p_event) else $error("event hidden by default");
  property p_menu;
    s_key(5'h04, 4'h0) |=> menu_page == $past(menu_page) + 2'h1;
  endproperty
  a_menu: assert property (p_menu) else $error("menu did not advance");
endmodule
bind breaker_keypad_control keypad_props u_props (.*);

// ### tb/breaker_keypad_control_bench.sv
`timescale 1ns/1ns
module breaker_keypad_control_bench;
  localparam int TK = 10;
  localparam logic [4:0] S = 5'h01, C = 5'h02, O = 5'h03, M = 5'h04;
  localparam logic [4:0] U = 5'h05, D = 5'h06, N = 5'h07, E = 5'h08;
  localparam logic [1:0] OK = keypad_pkg::RESP_OKAY;
  logic        aclk = 1'b0, aresetn = 1'b0, event_msg = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, x = 32'd82;
  logic [3:0]  s_axi_wstrb = 4'hf, key_digit, msg_code, cmd;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        key_valid, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid, sel_second_breaker;
  logic [4:0]  key_code;
  logic [2:0]  first_poles, second_poles;
  logic [1:0]  s_axi_bresp, s_axi_rresp, menu_page, first_position, second_position;
  logic [33:0] exp_q[$];
  logic [3:0]  cmd_q[$];
  int          n_errors = 0;
  int          total_checks = 0;
  always #4 aclk = ~aclk;
  keypad_partner u_kp (.*);
  breaker_keypad_control #(.TICK_CYCLES(TK)) u_dut
  (
    .*,
    .close_action_first_breaker  (cmd[3]),
    .close_action_second_breaker (cmd[2]),
    .open_action_first_breaker   (cmd[1]),
    .open_action_second_breaker  (cmd[0])
  );
  task chk(input logic [33:0] e, input logic [33:0] g);
    total_checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("ERROR %0t exp %h got %h", $time, e, g);
    end
  endtask
  function automatic logic [31:0] xs();
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  // Results are taken in the order they were noted
  always @(posedge aclk)
  begin
    if (s_axi_rvalid && s_axi_rready)
      chk(exp_q.pop_front(), {s_axi_rresp, s_axi_rdata});
    if (s_axi_bvalid && s_axi_bready)
      chk(exp_q.pop_front(), {s_axi_bresp, 32'h0});
    if (cmd != 4'h0)
      chk({30'h0, cmd_q.size() > 0 ? cmd_q.pop_front() : 4'h0}, {30'h0, cmd});
  end
  // Write: address and data offered together, each dropped once taken
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    exp_q.push_back({r, 32'h0});
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    fork
      begin
        do @(negedge aclk); while (!s_axi_awready);
        @(posedge aclk);
        s_axi_awvalid <= 1'b0;
      end
      begin
        do @(negedge aclk); while (!s_axi_wready);
        @(posedge aclk);
        s_axi_wvalid <= 1'b0;
      end
    join
    do @(negedge aclk); while (!s_axi_bvalid);
    @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back({OK, e});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(negedge aclk); while (!s_axi_arready);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    do @(negedge aclk); while (!s_axi_rvalid);
    @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask
  // Up to six presses, first key in the top bits
  task keys(input logic [29:0] k);
    for (int i = 5; i >= 0; i--)
      if (k[i*5+:5] != 5'h00)
        u_kp.press(k[i*5+:5], 4'h0);
  endtask
  task lvl(input logic [3:0] e);
    @(negedge aclk);
    chk({30'h0, e}, {30'h0, msg_code});
    @(posedge aclk);
  endtask
  task pole(input logic [2:0] p, input logic [1:0] e);
    u_kp.first_poles <= p;
    repeat (3) @(posedge aclk);
    chk({32'h0, e}, {32'h0, first_position});
  endtask
  task end_sim();
    n_errors += cmd_q.size();
    $display("Checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Hang guard, well past the longest permit wait
  initial
  begin
    #(8 * 60000);
    n_errors++;
    end_sim();
  end
  initial
  begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h00, keypad_pkg::CTRL_RST);
    rd(8'h0c, {16'h0, keypad_pkg::SET_MAX_RST});
    wr(8'h40, 32'h0, keypad_pkg::RESP_SLVERR);
    wr(8'h00, 32'h83, OK);
    cmd_q.push_back(4'h8);
    keys({S, S, C, C, 10'h0});
    cmd_q.push_back(4'h1);
    keys({S, S, S, O, O, 5'h0});
    cmd_q.push_back(4'h8);
    keys({S, S, S, S, C, C});
    keys({S, S, E, C, E, 5'h0});
    keys({S, S, C, E, 10'h0});
    keys({S, S, C, 15'h0});
    repeat (21 * TK) @(posedge aclk);
    keys({C, E, 20'h0});
    wr(8'h00, 32'h82, OK);
    keys({S, S, C, C, E, 5'h0});
    wr(8'h00, 32'h81, OK);
    cmd_q.push_back(4'h8);
    keys({S, S, S, C, C, 5'h0});
    chk(34'h0, {32'h0, second_position});
    wr(8'h00, 32'h87, OK);
    // Last command reopened the window; let it lapse first
    repeat (keypad_pkg::PERMIT_WINDOW_S * TK + 20) @(posedge aclk);
    keys({S, 25'h0});
    lvl(keypad_pkg::MSG_PASSWORD);
    wr(8'h00, 32'h8f, OK);
    cmd_q.push_back(4'h8);
    keys({S, C, C, 15'h0});
    repeat (keypad_pkg::PERMIT_WINDOW_S * TK + 20) @(posedge aclk);
    keys({S, 25'h0});
    lvl(keypad_pkg::MSG_PASSWORD);
    keys({E, M, M, M, M, M});
    chk(34'h1, {32'h0, menu_page});
    wr(8'h0c, 32'h30, OK);
    wr(8'h10, 32'h5, OK);
    u_kp.press(keypad_pkg::KEY_DIGIT, 4'h4);
    u_kp.press(keypad_pkg::KEY_DIGIT, 4'h5);
    keys({N, 25'h0});
    rd(8'h14, 32'h2d);
    keys({U, N, 20'h0});
    rd(8'h14, 32'h0);
    keys({D, N, 20'h0});
    rd(8'h14, 32'h30);
    keys({D, E, 20'h0});
    rd(8'h14, 32'h30);
    wr(8'h00, 32'h83, OK);
    repeat (8)
    begin
      void'(xs());
      event_msg <= x[3];
      u_kp.second_poles <= x[6:4];
      pole(x[2:0], {x[0], ~x[0]});
      chk({32'h0, x[4], ~x[4]}, {32'h0, second_position});
      lvl(x[3] ? keypad_pkg::MSG_EVENT : keypad_pkg::MSG_DEFAULT);
    end
    event_msg <= 1'b0;
    wr(8'h00, 32'ha3, OK);
    pole(3'b111, 2'b10);
    pole(3'b101, 2'b00);
    end_sim();
  end
endmodule
